// *** verif/ibt_irq_partner.sv ***
// Interrupt controller stand-in together with the on-chip CR oscillator.
`timescale 1ns/1ps
`default_nettype none
module ibt_irq_partner (
	// Timer side
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic intervalIrq,
	// Oscillator and request tally
	output logic crClk,
	output logic [15:0] reqCount
);
	logic irqSeen_q;
	// Offset start keeps CR edges away from clk_sys edges; 8 MHz nominal
	initial begin
		crClk = 1'b0;
		#7;
		forever #62.5 crClk = ~crClk;
	end
	// Requests are level; the controller latches each new assertion once
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			irqSeen_q <= 1'b0;
			reqCount <= 16'h0000;
		end else begin
			irqSeen_q <= intervalIrq;
			if (intervalIrq && !irqSeen_q) begin
				reqCount <= reqCount + 16'h0001;
			end
		end
	end
endmodule // ibt_irq_partner
`default_nettype wire

// *** verif/interval_base_timer_control_tb.sv ***
// Register-level testbench of the interval base timer.
`timescale 1ns/1ps
`default_nettype none
module interval_base_timer_control_tb;
	import ibt_pkg::*;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, rmwRead = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h1;
	logic [31:0] wdat = 32'h0000_0000, rdat, q, t0;
	logic ack, crClk, intervalIrq, sysIrq;
	logic [15:0] reqCount;
	logic [31:0] tick = 32'h0000_0000;
	logic [3:0] codes [3] = '{4'h4, 4'h0, 4'h5};
	logic [31:0] spans [3] = '{32'h0000_0400, 32'h0000_0800, 32'h0000_1000};
	int failCount = 0, checks = 0;
	ibt_interval_timer dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.rmwRead(rmwRead), .crClk(crClk), .intervalIrq(intervalIrq), .sysIrq(sysIrq));
	ibt_irq_partner model (.clk_sys(clk_sys), .sys_rst(sys_rst), .intervalIrq(intervalIrq),
		.crClk(crClk), .reqCount(reqCount));
	always #12.5 clk_sys = ~clk_sys;
	task conclude;
		$display("checks %0d mismatches %0d", checks, failCount);
		if (failCount == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Ceiling sits well above the roughly 26000 cycles the tests need
	always @(posedge clk_sys) begin
		tick <= tick + 32'h0000_0001;
		if (tick == 32'h0000_EA60) begin
			failCount++;
			conclude();
		end
	end
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failCount++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task access(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_sys); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
		access(1'b0, a, 32'h0000_0000);
		check(what, q, exp);
	endtask
	// Returns the tick at which the interrupt request is next seen high
	task waitIrq;
		do @(negedge clk_sys); while (intervalIrq !== 1'b1);
		t0 = tick;
	endtask
	task period(input logic [3:0] code, input logic [31:0] exp);
		logic [31:0] first;
		access(1'b1, CTL_ADDR, {24'h0, 8'h40 | {3'b000, code, 1'b0}});
		waitIrq();
		access(1'b1, CTL_ADDR, {24'h0, 8'h40 | {3'b000, code, 1'b0}});
		waitIrq();
		first = t0;
		rdChk("flag set", CTL_ADDR, {24'h0, 8'hC0 | {3'b000, code, 1'b0}});
		access(1'b1, CTL_ADDR, {24'h0, 8'h40 | {3'b000, code, 1'b0}});
		waitIrq();
		check("interval", t0 - first, exp);
	endtask
	initial begin
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rdChk("ctl reset", CTL_ADDR, 32'h0000_0000);
		access(1'b1, CTL_ADDR, 32'h0000_007F);
		rdChk("ctl rw bits", CTL_ADDR, 32'h0000_005E);
		sel <= 4'h0;
		access(1'b1, CTL_ADDR, 32'h0000_0000);
		sel <= 4'h1;
		rdChk("lane off write", CTL_ADDR, 32'h0000_005E);
		rdChk("unmapped", 8'h20, 32'h0000_0000);
		rdChk("clear event", STS_ADDR, 32'h0000_0002);
		access(1'b0, CNT_ADDR, 32'h0);
		check("counter wrap", {16'h0, q[23:8]}, 32'h0000_FFFF);
		access(1'b1, ICLR_ADDR, 32'h0000_0002);
		rdChk("status clr", STS_ADDR, 32'h0000_0000);
		$display("test registers done");
		for (int i = 0; i < 3; i++) period(codes[i], spans[i]);
		$display("test intervals done");
		access(1'b1, SRC_ADDR, 32'h0000_0001);
		period(4'h4, 32'h0000_0A00);
		access(1'b1, SRC_ADDR, 32'h0000_0000);
		$display("test cr clock done");
		// Old interval events are cleared so the next status rise comes with the flag set
		access(1'b1, CTL_ADDR, 32'h0000_0008);
		access(1'b1, ICLR_ADDR, 32'h0000_0001);
		access(1'b1, IEN_ADDR, 32'h0000_0001);
		do @(negedge clk_sys); while (sysIrq !== 1'b1);
		check("masked irq", {31'h0, intervalIrq}, 32'h0);
		access(1'b1, CTL_ADDR, 32'h0000_0088);
		rdChk("write one", CTL_ADDR, 32'h0000_0088);
		access(1'b1, CTL_ADDR, 32'h0000_0008);
		rmwRead <= 1'b1;
		rdChk("rmw read", CTL_ADDR, 32'h0000_0088);
		rmwRead <= 1'b0;
		rdChk("plain read", CTL_ADDR, 32'h0000_0008);
		access(1'b1, ICLR_ADDR, 32'h0000_0001);
		@(negedge clk_sys);
		check("sys irq clr", {31'h0, sysIrq}, 32'h0);
		check("requests", {16'h0, reqCount}, 32'h0000_000C);
		$display("test masking done");
		conclude();
	end
endmodule // interval_base_timer_control_tb
`default_nettype wire

// *** verilog/ibt_interval_timer.sv ***
// Interval base timer: 24-bit free-running down-counter, control register and Wishbone slave.
// Function
// - Set the interval-elapsed flag whenever the selected interval runs out.
// - Timer interrupt request is high exactly while flag and enable are both one.
// - Writing zero clears the flag; writing one changes nothing.
// - Read-modify-write reads return one for the flag.
// - Interrupt enable bit is read/write; zero blocks the request, one permits it.
// - Bit five reads zero and ignores writes.
// - Select 0100 gives 2^9, 0000 gives 2^10, 0101 gives 2^11 count periods.
// - Count period is two main clocks or one CR clock period.
// - Counter is a free-running 24-bit down-counter on the chosen count clock.
// - Selector picks one of 16 counter taps, intervals 2^9 to 2^24.
// - Bit zero is write-only, reads zero; writing one clears the counter.
`timescale 1ns/1ps
`default_nettype none
module ibt_interval_timer
	import ibt_pkg::*;
#(
	parameter int CNT_W = 24
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [DATA_W-1:0] wb_dat_i,
	output logic [DATA_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	// Read-modify-write marker for the current read
	input wire logic rmwRead,
	// Internal CR clock, asynchronous to clk_sys
	input wire logic crClk,
	// Interrupts
	output logic intervalIrq,
	output logic sysIrq
);

	// Bus handshake and decode
	logic ackQ;
	wire logic busReq;
	wire logic rdCapture;
	wire logic wrEn;
	wire logic hitCtl;
	wire logic hitSrc;
	wire logic hitSts;
	wire logic hitIclr;
	wire logic hitIen;
	wire logic hitCnt;
	wire logic ctlWr;
	wire logic srcWr;
	wire logic iclrWr;
	wire logic ienWr;

	assign busReq = wb_cyc_i && wb_stb_i;
	assign rdCapture = busReq && !wb_we_i && !ackQ;
	// Writes land on the edge at which the master samples ack
	assign wrEn = busReq && wb_we_i && ackQ && wb_sel_i[0];
	assign hitCtl = (wb_adr_i == CTL_ADDR);
	assign hitSrc = (wb_adr_i == SRC_ADDR);
	assign hitSts = (wb_adr_i == STS_ADDR);
	assign hitIclr = (wb_adr_i == ICLR_ADDR);
	assign hitIen = (wb_adr_i == IEN_ADDR);
	assign hitCnt = (wb_adr_i == CNT_ADDR);
	assign ctlWr = wrEn && hitCtl;
	assign srcWr = wrEn && hitSrc;
	assign iclrWr = wrEn && hitIclr;
	assign ienWr = wrEn && hitIen;

	// Control and configuration state
	logic flagQ;
	logic flagD;
	logic ieQ;
	logic [3:0] selQ;
	ibt_src_type srcQ;
	logic [EVT_W-1:0] stsQ;
	logic [EVT_W-1:0] stsD;
	logic [EVT_W-1:0] enQ;

	// Count clock generation
	logic halfQ;
	logic crSync1Q;
	logic crSync2Q;
	logic crPrevQ;
	wire logic mainTick;
	wire logic crTick;
	wire logic countTick;

	// Main clock halved: one count every second clk_sys edge
	assign mainTick = halfQ;
	// CR clock must stay below half of clk_sys to be seen on every edge
	assign crTick = crSync2Q && !crPrevQ;
	assign countTick = (srcQ == SRC_CR) ? crTick : mainTick;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			halfQ <= 1'b0;
			crSync1Q <= 1'b0;
			crSync2Q <= 1'b0;
			crPrevQ <= 1'b0;
		end else begin
			halfQ <= !halfQ;
			crSync1Q <= crClk;
			crSync2Q <= crSync1Q;
			crPrevQ <= crSync2Q;
		end
	end

	// Counter and tap selection
	logic [CNT_W-1:0] cntQ;
	logic [CNT_W-1:0] cntD;
	wire logic [CNT_W-1:0] cntDec;
	wire logic [4:0] tapIdx;
	wire logic counterClear;
	wire logic expire;

	assign cntDec = cntQ - {{(CNT_W-1){1'b0}}, 1'b1};
	assign counterClear = ctlWr && wb_dat_i[CLR_BIT];
	assign cntD = counterClear ? '0 : (countTick ? cntDec : cntQ);

	// Interval 2^n uses tap n-1: codes 0xxx interleave odd and even n, 1xxx run 17..24
	assign tapIdx = selQ[3] ? (LONG_TAP_BASE + {2'b00, selQ[2:0]})
		: ((selQ[2] ? ODD_TAP_BASE : EVEN_TAP_BASE) + {2'b00, selQ[1:0], 1'b0});

	// Tap falls only through a decrement, so a select change cannot fake an expiry
	assign expire = countTick && !counterClear && cntQ[tapIdx] && !cntDec[tapIdx];

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cntQ <= '0;
		end else begin
			cntQ <= cntD;
		end
	end

	// Flag: a new expiry wins over a clearing write in the same cycle
	assign flagD = expire ? 1'b1 : ((ctlWr && !wb_dat_i[FLAG_BIT]) ? 1'b0 : flagQ);

	// System interrupt status: sticky events, write-one-to-clear, set wins
	assign stsD = (stsQ & ~(iclrWr ? wb_dat_i[EVT_W-1:0] : EVT_RESET))
		| {counterClear, expire};

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			flagQ <= 1'b0;
			ieQ <= 1'b0;
			selQ <= SEL_RESET;
			srcQ <= SRC_MAIN_HALF;
			stsQ <= EVT_RESET;
			enQ <= EVT_RESET;
		end else begin
			flagQ <= flagD;
			stsQ <= stsD;
			if (ctlWr) begin
				ieQ <= wb_dat_i[IE_BIT];
				selQ <= wb_dat_i[SEL_HI:SEL_LO];
			end
			if (srcWr) begin
				srcQ <= ibt_src_type'(wb_dat_i[0]);
			end
			if (ienWr) begin
				enQ <= wb_dat_i[EVT_W-1:0];
			end
		end
	end

	// Interrupt outputs
	assign intervalIrq = flagQ && ieQ;
	assign sysIrq = |(stsQ & enQ);

	// Read data: reserved bit and clear strobe read zero, RMW reads see the flag set
	wire logic flagRead;
	wire logic [7:0] ctlRead;
	wire logic [DATA_W-1:0] rdData;

	assign flagRead = flagQ || rmwRead;
	assign ctlRead = {flagRead, ieQ, 1'b0, selQ, 1'b0};
	assign rdData = hitCtl ? {24'h00_0000, ctlRead}
		: hitSrc ? {31'h0000_0000, srcQ}
		: hitSts ? {{(DATA_W-EVT_W){1'b0}}, stsQ}
		: hitIen ? {{(DATA_W-EVT_W){1'b0}}, enQ}
		: hitCnt ? {{(DATA_W-CNT_W){1'b0}}, cntQ}
		: 32'h0000_0000;

	// One wait state: ack in the cycle after the request, dropped the cycle after
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			ackQ <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			ackQ <= busReq && !ackQ;
			if (rdCapture) begin
				wb_dat_o <= rdData;
			end
		end
	end

	assign wb_ack_o = ackQ;

	// Checks

	flagSet_a:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		expire |=> flagQ && intervalIrq == ieQ)
	else $error("flag not set after interval expiry");

	irqFollows_a:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		ctlWr && wb_dat_i[IE_BIT] && wb_dat_i[FLAG_BIT] && flagQ |=> intervalIrq)
	else $error("interrupt request missing while flag and enable are set");

	irqBlocked_a:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		ctlWr && !wb_dat_i[IE_BIT] |=> !intervalIrq)
	else $error("interrupt request present with enable cleared");

	flagClear_a:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		ctlWr && !wb_dat_i[FLAG_BIT] && !expire |=> !flagQ)
	else $error("writing zero did not clear the flag");

	flagKeep_a:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		ctlWr && wb_dat_i[FLAG_BIT] && !expire |=> flagQ == $past(flagQ))
	else $error("writing one changed the flag");

	rmwFlag_a:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		rdCapture && hitCtl && rmwRead |=> wb_dat_o[FLAG_BIT] && wb_ack_o)
	else $error("read-modify-write read did not return flag as one");

	enableStore_a:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		ctlWr |=> ieQ == $past(wb_dat_i[IE_BIT]))
	else $error("enable bit did not take the written value");

	reservedZero_a:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		rdCapture && hitCtl |=> !wb_dat_o[RSV_BIT] && !wb_dat_o[CLR_BIT])
	else $error("reserved or strobe bit read as one");

	tapShort_a:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		(selQ == 4'h4 |-> tapIdx == 5'h08) and (selQ == 4'h0 |-> tapIdx == 5'h09)
		and (selQ == 4'h5 |-> tapIdx == 5'h0A))
	else $error("interval select decoded to the wrong tap");

	mainHalf_a:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		mainTick |=> !mainTick ##1 mainTick)
	else $error("halved main clock tick out of step");

	crSingle_a:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		crTick |=> !crTick)
	else $error("CR clock edge counted twice");

	countDown_a:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		countTick && !counterClear |=> cntQ == $past(cntQ) - 24'h00_0001)
	else $error("counter did not decrement on a count tick");

	countHold_a:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		!countTick && !counterClear |=> $stable(cntQ))
	else $error("counter moved without a count tick");

	tapRange_a:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		tapIdx >= 5'h08 && tapIdx <= 5'h17)
	else $error("tap outside the sixteen permitted positions");

	counterZero_a:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		counterClear |=> cntQ == 24'h00_0000)
	else $error("counter not cleared by the strobe");

	expireOnce_a:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		expire |=> !expire)
	else $error("expiry lasted more than one cycle");

	// Further select codes against the tap table: short codes 1, 2, 3, 6, 7 and long codes 8 and F
	tapMid_a:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		(selQ == 4'h1 |-> tapIdx == 5'h0B) and (selQ == 4'h6 |-> tapIdx == 5'h0C)
		and (selQ == 4'h2 |-> tapIdx == 5'h0D))
	else $error("middle select code decoded to the wrong tap");

	tapUpper_a:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		(selQ == 4'h7 |-> tapIdx == 5'h0E) and (selQ == 4'h3 |-> tapIdx == 5'h0F))
	else $error("upper short select code decoded to the wrong tap");

	tapLong_a:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		(selQ == 4'h8 |-> tapIdx == 5'h10) and (selQ == 4'hF |-> tapIdx == 5'h17))
	else $error("long select code decoded to the wrong tap");

	flagHold_a:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		!expire && !ctlWr |=> $stable(flagQ))
	else $error("flag moved without expiry or control write");

	enableHold_a:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		!ctlWr |=> $stable(ieQ))
	else $error("enable bit moved without a control write");

	selStore_a:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		ctlWr |=> selQ == $past(wb_dat_i[SEL_HI:SEL_LO]))
	else $error("interval select did not take the written value");

	clearNoExpiry_a:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		counterClear && !flagQ |=> !flagQ)
	else $error("counter clear set the flag");

	ackAfterReq_a:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		busReq && !wb_ack_o |=> wb_ack_o)
	else $error("ack missing one cycle after a request");

	statusSticky_a:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		!iclrWr |=> (stsQ & $past(stsQ)) == $past(stsQ))
	else $error("status bit dropped without a clear write");

	selGate_a:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		busReq && wb_we_i && !wb_sel_i[0] |=> $stable(ieQ) && $stable(selQ))
	else $error("write with byte lane zero disabled changed the control register");

	ackPulse_a:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		wb_ack_o |=> !wb_ack_o)
	else $error("ack held for more than one cycle");

endmodule // ibt_interval_timer
`default_nettype wire

// *** verilog/ibt_pkg.sv ***
// Shared constants of the interval base timer: register map, field layout, reset values.
`default_nettype none
package ibt_pkg;
	// Wishbone geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte addresses
	localparam logic [7:0] CTL_ADDR = 8'h00;
	localparam logic [7:0] SRC_ADDR = 8'h04;
	localparam logic [7:0] STS_ADDR = 8'h08;
	localparam logic [7:0] ICLR_ADDR = 8'h0C;
	localparam logic [7:0] IEN_ADDR = 8'h10;
	localparam logic [7:0] CNT_ADDR = 8'h14;

	// Control register field positions
	localparam int FLAG_BIT = 7;
	localparam int IE_BIT = 6;
	localparam int RSV_BIT = 5;
	localparam int SEL_HI = 4;
	localparam int SEL_LO = 1;
	localparam int CLR_BIT = 0;

	// Event bits of the system interrupt status, clear and enable registers
	localparam int EVT_W = 2;
	localparam int EVT_INTERVAL = 0;
	localparam int EVT_CLEARED = 1;

	// Reset values
	localparam logic [3:0] SEL_RESET = 4'h0;
	localparam logic SRC_RESET = 1'b0;
	localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;

	// Tap decode: tap bit index is interval exponent minus one
	localparam logic [4:0] EVEN_TAP_BASE = 5'h09;
	localparam logic [4:0] ODD_TAP_BASE = 5'h08;
	localparam logic [4:0] LONG_TAP_BASE = 5'h10;

	// Count clock source encodings
	typedef enum logic {
		SRC_MAIN_HALF = 1'b0,
		SRC_CR = 1'b1
	} ibt_src_type;
endpackage
`default_nettype wire
